/* rtl/dist_filter_regs.vh */
`ifndef DIST_FILTER_REGS_VH
`define DIST_FILTER_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define A_CTRL 12'h000
`define A_REJ 12'h004
`define A_AVG 12'h008
`define A_RATE 12'h00c
`define A_CMD 12'h010
`define A_STAT 12'h014

// ----------------------------------------
// Control fields
// ----------------------------------------
`define F_REJ 1:0
`define F_AVG 3:2
`define F_LIM 5:4
`define B_UNLOCK 6
`define B_POLL 7
`define B_SYNC 8
`define F_PH 11:9
`define B_STREAM 12
`define F_M 9:0
`define F_X 18:16
`define F_Y 22:20
`define F_N 7:0
`define B_SFTOG 0
`define B_DEFAULTS 1
`define B_ERRCLR 2

// ----------------------------------------
// Stage modes
// ----------------------------------------
`define REJ_OFF 2'h0
`define REJ_NEAR 2'h1
`define REJ_FAR 2'h2
`define REJ_VOTE 2'h3
`define AVG_OFF 2'h0
`define AVG_BOX 2'h1
`define AVG_RUN 2'h2
`define LIM_OFF 2'h0
`define LIM_RATE 2'h1
`define LIM_SF 2'h2

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CTRL_RST 13'h0200
`define M_RST 10'h002
`define X_RST 3'h1
`define Y_RST 3'h2
`define N_RST 8'h02
`define RATE_RST 32'h0010_0000
`define M_MIN 10'h002
`define M_MAX 10'h3e7
`define X_MIN 3'h1
`define Y_MIN 3'h2
`define N_MIN 8'h02
`define RATE_FRAC 20
`define SF_MAX 16'h0100

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 125000000
`define TICK_MS 1
`define TICK_CYC (`CLK_HZ / 1000 * `TICK_MS)

`endif

/* rtl/distance_filter_pipeline.v */
// What this block does
// - Outputs update once per finished measurement; no filters means one interval.
// - Serial distance streaming is suppressed while phase sync runs.
// - Under phase sync only one sample in every phase-count samples is used.
// - After reset all filter stages are off, so raw samples drive outputs.
// - Order is rejection, averaging, limiting; one option per stage; off passes.
// - Unlock mode bypasses all stages whatever is selected.
// - First valid sample after power-on initialises every stage.
// - Closest mode forwards the minimum of each group of M, M 2..999.
// - Farthest mode forwards the maximum of each group of M.
// - Vote mode passes a sample when X of previous Y lie within 1/16.
// - Vote mode discards samples while the target stays unstable.
// - Vote X accepted in 1..7, Y in 2..7.
// - While votes pass, every sample is forwarded without added delay.
// - Instability freezes averaging and limiting at the current distance.
// - Boxcar averages N samples, N 2..255, once per N, then restarts.
// - Running average emits the mean of the last N after every input.
// - Rate clamp limits output change per millisecond, both directions.
// - Slow-fast approaches a jump slowly, speeding up while target holds.
// - Slow-fast toggles by command, cleared by defaults restore.
// - Vote, running average and slow-fast are refused in poll mode.
// - Poll mode runs the chain once per poll; a mid-run poll queues one.
//
// The register addresses and the APB slave port were left to the implementer.
`include "dist_filter_regs.vh"

module distance_filter_pipeline #(
  parameter DW = 16,
  parameter TICK_CYC = `TICK_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire raw_valid,
  input wire [DW-1:0] raw_dist,
  input wire poll_pin,
  output reg meas_run,
  output reg out_valid,
  output reg [DW-1:0] out_dist,
  output reg stream_ok
);

// ----------------------------------------
// Helpers
// ----------------------------------------
function [DW-1:0] adiff;
  input [DW-1:0] a;
  input [DW-1:0] b;
  begin
    adiff = (a > b) ? a - b : b - a;
  end
endfunction

function [DW-1:0] toward;
  input [DW-1:0] cur;
  input [DW-1:0] tgt;
  input [DW-1:0] step;
  begin
    if (adiff(cur, tgt) <= step) begin
      toward = tgt;
    end else if (tgt > cur) begin
      toward = cur + step;
    end else begin
      toward = cur - step;
    end
  end
endfunction

// Restoring divide, truncates toward zero
function [DW-1:0] div;
  input [DW+7:0] a;
  input [7:0] b;
  reg [DW+7:0] q;
  reg [8:0] r;
  integer i;
  begin
    q = a;
    r = 9'h000;
    for (i = DW + 7; i >= 0; i = i - 1) begin
      r = {r[7:0], q[i]};
      if (r >= {1'b0, b}) begin
        r = r - {1'b0, b};
        q[i] = 1'b1;
      end else begin
        q[i] = 1'b0;
      end
    end
    div = q[DW-1:0];
  end
endfunction

// Poll mode may not carry disallowed selections
function [12:0] ctrl_fix;
  input [12:0] v;
  begin
    ctrl_fix = v;
    if (v[`B_POLL]) begin
      if (v[`F_REJ] == `REJ_VOTE) ctrl_fix[`F_REJ] = `REJ_OFF;
      if (v[`F_AVG] == `AVG_RUN) ctrl_fix[`F_AVG] = `AVG_OFF;
      if (v[`F_LIM] == `LIM_SF) ctrl_fix[`F_LIM] = `LIM_OFF;
    end
  end
endfunction

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg [12:0] ctrl_reg;
reg [9:0] m_reg;
reg [2:0] x_reg;
reg [2:0] y_reg;
reg [7:0] n_reg;
reg [31:0] rate_reg;
reg cfg_err_reg;
reg primed_reg;
reg stable_reg;
reg run_reg;
reg pend_reg;

wire wr = psel & penable & pready & pwrite;
wire setup = psel & ~penable;
wire poll = ctrl_reg[`B_POLL];
wire [1:0] rej_m = ctrl_reg[`B_UNLOCK] ? `REJ_OFF : ctrl_reg[`F_REJ];
wire [1:0] avg_m = ctrl_reg[`B_UNLOCK] ? `AVG_OFF : ctrl_reg[`F_AVG];
wire [1:0] lim_m = ctrl_reg[`B_UNLOCK] ? `LIM_OFF : ctrl_reg[`F_LIM];
wire mapped = (paddr == `A_CTRL) | (paddr == `A_REJ) | (paddr == `A_AVG) |
  (paddr == `A_RATE) | (paddr == `A_CMD) | (paddr == `A_STAT);
wire [12:0] wctrl = ctrl_fix(pwdata[12:0]);
wire w_ctrl = wr & (paddr == `A_CTRL);
wire w_rej = wr & (paddr == `A_REJ);
wire w_avg = wr & (paddr == `A_AVG);
wire w_cmd = wr & (paddr == `A_CMD);
wire rej_ok = (pwdata[`F_M] >= `M_MIN) & (pwdata[`F_M] <= `M_MAX) &
  (pwdata[`F_X] >= `X_MIN) & (pwdata[`F_Y] >= `Y_MIN);
wire n_ok = pwdata[`F_N] >= `N_MIN;
wire sf_refuse = w_cmd & pwdata[`B_SFTOG] & poll;
wire cfg_bad = (w_ctrl & (wctrl != pwdata[12:0])) | (w_rej & ~rej_ok) |
  (w_avg & ~n_ok) | sf_refuse;
// Control, rejection or averaging writes, or a defaults restore, re-seed the stages from the next sample
wire reprime = w_ctrl | w_rej | w_avg | (w_cmd & pwdata[`B_DEFAULTS]);

// Distance zero-extended to the 16-bit status field
reg [15:0] dist16;
always @* begin
  dist16 = 16'h0000;
  dist16[DW-1:0] = out_dist;
end

reg [31:0] rd_mux;
always @* begin
  case (paddr)
    `A_CTRL: rd_mux = {19'h00000, ctrl_reg};
    `A_REJ: rd_mux = {9'h000, y_reg, 1'b0, x_reg, 6'h00, m_reg};
    `A_AVG: rd_mux = {24'h000000, n_reg};
    `A_RATE: rd_mux = rate_reg;
    `A_STAT: rd_mux = {12'h000, cfg_err_reg, run_reg, primed_reg, stable_reg, dist16};
    default: rd_mux = 32'h0000_0000;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h0000_0000;
    pready <= 1'b0;
    pslverr <= 1'b0;
    ctrl_reg <= `CTRL_RST;
    m_reg <= `M_RST;
    x_reg <= `X_RST;
    y_reg <= `Y_RST;
    n_reg <= `N_RST;
    rate_reg <= `RATE_RST;
    cfg_err_reg <= 1'b0;
  end else if (clk_en) begin
    pready <= setup;
    pslverr <= setup & (~mapped | (pwrite & (paddr == `A_STAT)));
    if (setup & ~pwrite) begin
      prdata <= rd_mux;
    end
    if (w_ctrl) begin
      ctrl_reg <= wctrl;
    end
    if (w_rej & rej_ok) begin
      m_reg <= pwdata[`F_M];
      x_reg <= pwdata[`F_X];
      y_reg <= pwdata[`F_Y];
    end
    if (w_avg & n_ok) begin
      n_reg <= pwdata[`F_N];
    end
    if (wr & (paddr == `A_RATE)) begin
      rate_reg <= pwdata;
    end
    if (w_cmd & pwdata[`B_DEFAULTS]) begin
      ctrl_reg <= `CTRL_RST;
      m_reg <= `M_RST;
      x_reg <= `X_RST;
      y_reg <= `Y_RST;
      n_reg <= `N_RST;
    end else if (w_cmd & pwdata[`B_SFTOG] & ~poll) begin
      // Toggled on while unlocked, it acts only once unlock is left
      ctrl_reg[`F_LIM] <= (ctrl_reg[`F_LIM] == `LIM_SF) ? `LIM_OFF : `LIM_SF;
    end
    // A new error in the clearing cycle keeps the flag set
    if (cfg_bad) begin
      cfg_err_reg <= 1'b1;
    end else if (w_cmd & pwdata[`B_ERRCLR]) begin
      cfg_err_reg <= 1'b0;
    end
  end
end

// ----------------------------------------
// Sample admission: poll, sync phase
// ----------------------------------------
reg poll_m;
reg poll_s;
reg poll_d;
reg [2:0] ph_cnt;
wire poll_rise = poll_s & ~poll_d;
wire [2:0] ph_last = (ctrl_reg[`F_PH] == 3'h0) ? 3'h0 : ctrl_reg[`F_PH] - 3'h1;
wire ph_ok = ~ctrl_reg[`B_SYNC] | (ph_cnt == 3'h0);
wire take = raw_valid & ph_ok & (~poll | run_reg) & ~reprime;
wire first = take & ~primed_reg;
wire run_go = poll & poll_rise & ~run_reg;
reg out_next;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    poll_m <= 1'b0;
    poll_s <= 1'b0;
    poll_d <= 1'b0;
    ph_cnt <= 3'h0;
    run_reg <= 1'b0;
    pend_reg <= 1'b0;
    primed_reg <= 1'b0;
    meas_run <= 1'b0;
    stream_ok <= 1'b0;
  end else if (clk_en) begin
    poll_m <= poll_pin;
    poll_s <= poll_m;
    poll_d <= poll_s;
    if (raw_valid) begin
      ph_cnt <= (ph_cnt >= ph_last) ? 3'h0 : ph_cnt + 3'h1;
    end
    if (reprime) begin
      primed_reg <= 1'b0;
    end else if (first) begin
      primed_reg <= 1'b1;
    end
    if (~poll) begin
      run_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (run_reg & out_next) begin
      run_reg <= pend_reg;
      pend_reg <= 1'b0;
    end else if (poll_rise) begin
      run_reg <= 1'b1;
      pend_reg <= run_reg;
    end
    meas_run <= ~poll | run_reg;
    stream_ok <= ctrl_reg[`B_STREAM] & ~ctrl_reg[`B_SYNC];
  end
end

// ----------------------------------------
// Stage 1: input rejection
// ----------------------------------------
reg s1_v;
reg s1_f;
reg [DW-1:0] s1_d;
reg [9:0] rcnt;
reg [DW-1:0] best;
reg [DW-1:0] hist [0:6];
reg [3:0] votes;
integer i;
integer j;

always @* begin
  votes = 4'h0;
  for (i = 0; i < 7; i = i + 1) begin
    if ((i < y_reg) && (adiff(hist[i], raw_dist) <= (raw_dist >> 4))) begin
      votes = votes + 4'h1;
    end
  end
end

wire [DW-1:0] pick = (rcnt == 10'h000) ? raw_dist :
  (rej_m == `REJ_NEAR) ? ((raw_dist < best) ? raw_dist : best) :
  ((raw_dist > best) ? raw_dist : best);
wire vote_ok = {1'b0, x_reg} <= votes;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    s1_v <= 1'b0;
    s1_f <= 1'b0;
    s1_d <= {DW{1'b0}};
    rcnt <= 10'h000;
    best <= {DW{1'b0}};
    stable_reg <= 1'b0;
    for (j = 0; j < 7; j = j + 1) begin
      hist[j] <= {DW{1'b0}};
    end
  end else if (clk_en) begin
    s1_v <= 1'b0;
    s1_f <= first;
    if (run_go | reprime) begin
      rcnt <= 10'h000;
    end else if (first) begin
      s1_v <= 1'b1;
      s1_d <= raw_dist;
      rcnt <= 10'h000;
      stable_reg <= 1'b1;
      for (j = 0; j < 7; j = j + 1) begin
        hist[j] <= raw_dist;
      end
    end else if (take) begin
      case (rej_m)
        `REJ_NEAR, `REJ_FAR: begin
          best <= pick;
          if (rcnt >= m_reg - 10'h001) begin
            s1_v <= 1'b1;
            s1_d <= pick;
            rcnt <= 10'h000;
          end else begin
            rcnt <= rcnt + 10'h001;
          end
        end
        `REJ_VOTE: begin
          stable_reg <= vote_ok;
          s1_v <= vote_ok;
          s1_d <= raw_dist;
          hist[0] <= raw_dist;
          for (j = 1; j < 7; j = j + 1) begin
            hist[j] <= hist[j-1];
          end
        end
        default: begin
          s1_v <= 1'b1;
          s1_d <= raw_dist;
        end
      endcase
    end
  end
end

// ----------------------------------------
// Stage 2: averaging
// ----------------------------------------
reg s2_v;
reg s2_f;
reg [DW-1:0] s2_d;
reg [7:0] bcnt;
reg [DW+7:0] acc;
reg [DW+7:0] rsum;
reg [DW-1:0] rb [0:254];
reg [7:0] ridx;
reg [7:0] fill;
reg [DW-1:0] seed;

wire [DW+7:0] box_sum = acc + {8'h00, s1_d};
wire [DW-1:0] oldest = (fill > ridx) ? rb[ridx] : seed;
wire [DW+7:0] run_sum = rsum + {8'h00, s1_d} - {8'h00, oldest};
wire [DW+7:0] seed_sum = {8'h00, s1_d} * {{DW{1'b0}}, n_reg};

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    s2_v <= 1'b0;
    s2_f <= 1'b0;
    s2_d <= {DW{1'b0}};
    bcnt <= 8'h00;
    acc <= {(DW+8){1'b0}};
    rsum <= {(DW+8){1'b0}};
    ridx <= 8'h00;
    fill <= 8'h00;
    seed <= {DW{1'b0}};
  end else if (clk_en) begin
    s2_v <= 1'b0;
    s2_f <= s1_f;
    if (run_go | reprime) begin
      bcnt <= 8'h00;
      acc <= {(DW+8){1'b0}};
    end else if (s1_v & s1_f) begin
      s2_v <= 1'b1;
      s2_d <= s1_d;
      seed <= s1_d;
      rsum <= seed_sum;
      ridx <= 8'h00;
      fill <= 8'h00;
    end else if (s1_v) begin
      case (avg_m)
        `AVG_BOX: begin
          if (bcnt >= n_reg - 8'h01) begin
            s2_v <= 1'b1;
            s2_d <= div(box_sum, n_reg);
            bcnt <= 8'h00;
            acc <= {(DW+8){1'b0}};
          end else begin
            bcnt <= bcnt + 8'h01;
            acc <= box_sum;
          end
        end
        `AVG_RUN: begin
          // Slots never written count as the seed sample
          rb[ridx] <= s1_d;
          rsum <= run_sum;
          ridx <= (ridx >= n_reg - 8'h01) ? 8'h00 : ridx + 8'h01;
          fill <= (fill < n_reg) ? fill + 8'h01 : fill;
          s2_v <= 1'b1;
          s2_d <= div(run_sum, n_reg);
        end
        default: begin
          s2_v <= 1'b1;
          s2_d <= s1_d;
        end
      endcase
    end
  end
end

// ----------------------------------------
// Stage 3: distance limiting
// ----------------------------------------
reg [16:0] tick_cnt;
reg [15:0] ms_since;
reg [DW-1:0] sf_tgt;
reg [DW-1:0] sf_step;
reg [DW-1:0] out_calc;
reg [DW-1:0] sf_next;

wire [47:0] rate_prod = rate_reg * {16'h0000, ms_since};
// Saturate: a clamp step wider than the distance is no clamp at all
wire [DW-1:0] rate_step = (|rate_prod[47:`RATE_FRAC+DW]) ? {DW{1'b1}} :
  rate_prod[`RATE_FRAC+DW-1:`RATE_FRAC];

always @* begin
  sf_next = sf_step;
  out_calc = s2_d;
  out_next = s2_v;
  if (s2_v & ~s2_f) begin
    case (lim_m)
      `LIM_RATE: begin
        out_calc = toward(out_dist, s2_d, rate_step);
      end
      `LIM_SF: begin
        if (adiff(s2_d, sf_tgt) > (s2_d >> 4)) begin
          sf_next = {{(DW-1){1'b0}}, 1'b1};
        end else if (sf_step < `SF_MAX) begin
          sf_next = sf_step << 1;
        end
        out_calc = toward(out_dist, s2_d, sf_next);
      end
      default: begin
        out_calc = s2_d;
      end
    endcase
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    out_valid <= 1'b0;
    out_dist <= {DW{1'b0}};
    tick_cnt <= 17'h00000;
    ms_since <= 16'h0000;
    sf_tgt <= {DW{1'b0}};
    sf_step <= {{(DW-1){1'b0}}, 1'b1};
  end else if (clk_en) begin
    out_valid <= out_next;
    if (tick_cnt >= TICK_CYC[16:0] - 17'h00001) begin
      tick_cnt <= 17'h00000;
      if (~&ms_since) begin
        ms_since <= ms_since + 16'h0001;
      end
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
    if (out_next) begin
      out_dist <= out_calc;
      ms_since <= 16'h0000;
      sf_tgt <= s2_d;
      sf_step <= s2_f ? {{(DW-1){1'b0}}, 1'b1} : sf_next;
    end
  end
end

endmodule

/* testbench/dist_filter_monitor.sv */
module dist_filter_monitor #(
  parameter DW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire raw_valid,
  input wire [DW-1:0] raw_dist,
  input wire poll_pin,
  input wire meas_run,
  input wire out_valid,
  input wire [DW-1:0] out_dist,
  input wire stream_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_ready_after_setup: assert property (psel && !penable && clk_en |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_rdata_holds: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved without a read");
  a_refused_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_unmapped_err: assert property (pready && (paddr > 12'h014 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  a_status_write_err: assert property (pready && pwrite && paddr == 12'h014 |-> pslverr)
    else $error("status write not refused");

  // ----------------------------------------
  // Distance output
  // ----------------------------------------
  a_out_single: assert property (out_valid |=> !out_valid)
    else $error("output update longer than one cycle");
  a_out_holds: assert property ($changed(out_dist) |-> out_valid)
    else $error("distance moved without update");
  a_out_from_sample: assert property (out_valid |-> $past(raw_valid, 3))
    else $error("update not three edges after a sample");

  c_update: cover property (out_valid);
  c_refused: cover property (pslverr);
  c_run_end: cover property ($fell(meas_run));
  c_stream: cover property ($rose(stream_ok));
endmodule

bind distance_filter_pipeline dist_filter_monitor #(.DW(DW)) mon (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid), .raw_dist(raw_dist),
  .poll_pin(poll_pin), .meas_run(meas_run), .out_valid(out_valid), .out_dist(out_dist),
  .stream_ok(stream_ok));

/* testbench/sensor_front_end.sv */
module sensor_front_end (
  input wire pclk,
  input wire meas_run,
  output logic raw_valid,
  output logic [15:0] raw_dist
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    raw_valid = 1'b0;
    raw_dist = 16'h5a5a;
  end

  // Waits up to 500 cycles for meas_run, then measures; the distance bus goes inverted afterwards so stale data never looks valid
  task automatic send(input logic [15:0] d);
    int i;
    i = 0;
    while (meas_run !== 1'b1 && i < 500) begin
      @(posedge pclk);
      i++;
    end
    @(posedge pclk);
    raw_valid <= 1'b1;
    raw_dist <= d;
    @(posedge pclk);
    raw_valid <= 1'b0;
    raw_dist <= ~d;
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* testbench/test_distance_filter_pipeline.sv */
`include "dist_filter_regs.vh"

module test_distance_filter_pipeline;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, poll_pin, pready, pslverr, er;
  logic raw_valid, meas_run, out_valid, stream_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] raw_dist, out_dist, last_out;
  int n_mismatch, checks, n_out, cyc, n0;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Short tick keeps the rate timer fast in simulation
  distance_filter_pipeline #(.DW(16), .TICK_CYC(8)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid), .raw_dist(raw_dist), .poll_pin(poll_pin),
    .meas_run(meas_run), .out_valid(out_valid), .out_dist(out_dist), .stream_ok(stream_ok));

  sensor_front_end fe (.pclk(pclk), .meas_run(meas_run), .raw_valid(raw_valid), .raw_dist(raw_dist));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (out_valid === 1'b1) begin
      n_out++;
      last_out = out_dist;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sends one sample, then expects inc updates and, if any, the distance e
  task automatic smp(input logic [15:0] d, input int inc, input logic [15:0] e);
    n0 = n_out;
    fe.send(d);
    repeat (6) @(posedge pclk);
    chk(n_out - n0, inc);
    if (inc > 0) chk(last_out, e);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    poll_pin = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    apb(1'b0, `A_REJ, 32'h0);
    chk(rd, 32'h0021_0002);
    apb(1'b0, `A_AVG, 32'h0);
    chk(rd, `N_RST);
    apb(1'b0, `A_RATE, 32'h0);
    chk(rd, `RATE_RST);
    apb(1'b0, 12'h018, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `A_STAT, 32'h5);
    chk(er, 1'b1);
    smp(16'h0064, 1, 16'h0064);
    smp(16'h0025, 1, 16'h0025);
    $display("test reset and raw done");
    apb(1'b1, `A_REJ, 32'h0021_0003);
    for (int k = 1; k <= 2; k++) begin
      apb(1'b1, `A_CTRL, k);
      smp(16'h01f4, 1, 16'h01f4);
      smp(16'h0032, 0, 16'h0);
      smp(16'h001e, 0, 16'h0);
      smp(16'h0028, 1, (k == 1) ? 16'h001e : 16'h0032);
    end
    apb(1'b1, `A_REJ, 32'h0021_0001);
    apb(1'b0, `A_REJ, 32'h0);
    chk(rd, 32'h0021_0003);
    apb(1'b1, `A_REJ, 32'h0070_0003);
    apb(1'b0, `A_REJ, 32'h0);
    chk(rd, 32'h0021_0003);
    $display("test closest and farthest done");
    apb(1'b1, `A_CTRL, 32'h4);
    smp(16'h0064, 1, 16'h0064);
    smp(16'h000a, 0, 16'h0);
    smp(16'h000d, 1, 16'h000b);
    apb(1'b1, `A_CTRL, 32'h8);
    smp(16'h0014, 1, 16'h0014);
    smp(16'h0014, 1, 16'h0014);
    smp(16'h001e, 1, 16'h0019);
    $display("test averaging done");
    apb(1'b1, `A_CTRL, 32'h41);
    smp(16'h01f4, 1, 16'h01f4);
    smp(16'h0046, 1, 16'h0046);
    smp(16'h005a, 1, 16'h005a);
    $display("test unlock done");
    apb(1'b1, `A_CTRL, 32'h1500);
    repeat (2) @(posedge pclk);
    chk(stream_ok, 1'b0);
    n0 = n_out;
    repeat (4) fe.send(16'h0050);
    repeat (6) @(posedge pclk);
    chk(n_out - n0, 2);
    apb(1'b1, `A_CTRL, 32'h1000);
    repeat (2) @(posedge pclk);
    chk(stream_ok, 1'b1);
    $display("test sync done");
    apb(1'b1, `A_CMD, 32'h4);
    apb(1'b1, `A_CTRL, 32'h0ab);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, 32'h080);
    apb(1'b1, `A_CMD, 32'h1);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rd[19], 1'b1);
    chk(meas_run, 1'b0);
    poll_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    poll_pin <= 1'b0;
    smp(16'h004d, 1, 16'h004d);
    chk(meas_run, 1'b0);
    apb(1'b1, `A_CMD, 32'h4);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rd[19], 1'b0);
    $display("test poll done");
    apb(1'b1, `A_CTRL, 32'h0);
    apb(1'b1, `A_CMD, 32'h1);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, 32'h020);
    apb(1'b1, `A_CMD, 32'h2);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    $display("test commands done");
    apb(1'b1, `A_REJ, 32'h0032_0003);
    apb(1'b1, `A_CTRL, 32'h3);
    smp(16'h0100, 1, 16'h0100);
    smp(16'h0104, 1, 16'h0104);
    smp(16'h0200, 0, 16'h0);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rd[16:0], {1'b0, 16'h0104});
    smp(16'h0200, 0, 16'h0);
    smp(16'h0200, 1, 16'h0200);
    $display("test vote done");
    apb(1'b1, `A_RATE, 32'h0040_0000);
    apb(1'b1, `A_CTRL, 32'h10);
    n0 = n_out;
    fe.send(16'h0100);
    for (int k = 0; k < 2; k++) begin
      // Takes nine cycles apart leave exactly one tick between updates
      repeat (3) @(posedge pclk);
      fe.send(k ? 16'h0000 : 16'h0200);
      chk(last_out, k ? 16'h0100 : 16'h0104);
    end
    chk(n_out - n0, 3);
    apb(1'b1, `A_CTRL, 32'h20);
    smp(16'h0100, 1, 16'h0100);
    smp(16'h0200, 1, 16'h0101);
    smp(16'h0200, 1, 16'h0103);
    smp(16'h0200, 1, 16'h0107);
    clk_en <= 1'b0;
    smp(16'h0300, 0, 16'h0);
    clk_en <= 1'b1;
    $display("test rate and slow-fast done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    smp(16'h0077, 1, 16'h0077);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
